// *** design/eelc_consts.vh ***
// register indices, field positions, reset values and timing figures of the eee lpi control block
`ifndef EELC_CONSTS_VH
`define EELC_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define EELC_IDX_W        10
`define EELC_IDX_EEE_STAT 10'h0e4
`define EELC_IDX_RECOV    10'h0e6
`define EELC_IDX_BL1      10'h0e7
`define EELC_IDX_PCS      10'h0f2
`define EELC_IDX_EMPTY    10'h0f4
`define EELC_IDX_BL2      10'h0f6

// reset values
`define EELC_RST_RECOV    8'h27
`define EELC_RST_SRC_THR  6'h08
`define EELC_RST_ALL_THR  8'h40
`define EELC_RST_EMPTY    16'h03e8
`define EELC_RST_PCS_LO   8'h27
`define EELC_RST_PCS_HI   2'h0
`define EELC_RST_PCS_R9   1'h1
`define EELC_RST_NP_EN    1'h1
`define EELC_RST_ST_R15   1'h1
`define EELC_RST_ST_R98   2'h0
`define EELC_BL2_HI_RO    8'h01
`define EELC_ST_NPLOC     2'h3

// field positions
`define EELC_ST_TXLPI_LH  13
`define EELC_ST_RXLPI_LH  11
`define EELC_BL1_TRAF_EN  7
`define EELC_PCS_NP_EN    8
`define EELC_PCS_R9       9

// buffer threshold units as shifts of the byte count: 512 and 128 bytes
`define EELC_SRC_SHIFT    9
`define EELC_ALL_SHIFT    7

// timing
`define EELC_CLK_PERIOD_NS 8
`define EELC_RECOV_UNIT_NS 640
`define EELC_EMPTY_UNIT_NS 1300000
`define EELC_PRE_W         18

`endif

// *** design/eelc_unit_timer.v ***
// prescaled unit counter that flags when a programmed number of units has passed
`timescale 1ns/10ps
module eelc_unit_timer #(
  parameter UNIT_CYC = 80,  // clock cycles per unit
  parameter PW       = 18,  // prescaler width
  parameter CW       = 16,  // unit counter width
  parameter STRICT   = 1    // 1: done when units exceed limit, 0: when they reach it
) (
  input  wire          clk,    // system clock
  input  wire          resetn, // async reset, active low
  input  wire          run,    // count while high, restart from zero when low
  input  wire [CW-1:0] limit,  // programmed unit count
  output reg           done_r  // limit passed (STRICT 1) or reached (STRICT 0) since run rose
);

// the integer form keeps the subtraction at full width before the cut to the prescaler width
localparam integer  PRE_LAST_I = UNIT_CYC - 1;
localparam [PW-1:0] PRE_LAST   = PRE_LAST_I[PW-1:0];
localparam [CW-1:0] UNITS_MAX  = {CW{1'h1}};

reg [PW-1:0] pre_r;
reg [CW-1:0] units_r;

always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    pre_r   <= {PW{1'h0}};
    units_r <= {CW{1'h0}};
    done_r  <= 1'h0;
  end else if (!run) begin
    pre_r   <= {PW{1'h0}};
    units_r <= {CW{1'h0}};
    done_r  <= 1'h0;
  end else begin
    if (pre_r == PRE_LAST) begin
      pre_r <= {PW{1'h0}};
      // saturate so a long idle never wraps back under the limit
      if (units_r != UNITS_MAX) begin
        units_r <= units_r + 1'h1;
      end
    end else begin
      pre_r <= pre_r + 1'h1;
    end
    done_r <= (STRICT != 0) ? (units_r > limit) : (units_r >= limit);
  end
end

endmodule

// *** design/eelc_load_cmp.v ***
// registered compare of a buffer byte count against a threshold in coarse units
`timescale 1ns/10ps
module eelc_load_cmp #(
  parameter BW    = 14, // byte count width
  parameter TW    = 8,  // threshold width
  parameter SHIFT = 7   // log2 of bytes per threshold unit
) (
  input  wire          clk,    // system clock
  input  wire          resetn, // async reset, active low
  input  wire [BW-1:0] usage,  // buffer usage in bytes
  input  wire [TW-1:0] thr,    // threshold in units
  output reg           over_r  // usage above threshold
);

localparam XW = BW + TW + SHIFT;

wire [XW-1:0] useX = {{(TW+SHIFT){1'h0}}, usage};
wire [XW-1:0] thrX = {{BW{1'h0}}, thr, {SHIFT{1'h0}}};

always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    over_r <= 1'h0;
  end else begin
    over_r <= (useX > thrX);
  end
end

endmodule

// *** design/eelc_lpi_ctrl.v ***
// eee low power idle entry and exit control with its wishbone register file
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "eelc_consts.vh"

// How it works
// - status bit 2 is read-only and shows whether this end is able to exchange next pages.
// - status bit 1 latches high when a new negotiation page arrives and stays high until cleared.
// - status bit 0 is read-only and reads 1 when the link partner can auto-negotiate, else 0.
// - after leaving lpi the transmitter waits the 8-bit recovery count in 640 ns steps, reset 0x27.
// - with control bit 7 set, input traffic withdraws a pending lpi request; with it clear it does not.
// - lpi ends for a port whose buffer usage passes a 6-bit threshold of 512-byte units, reset 0x08.
// - next page exchange runs during negotiation while bit 8 of the pcs control word is 1, its reset.
// - an lpi request rises once a transmit queue stays empty past a 16-bit time in 1.3 ms units, reset 0x03e8.
// - lpi ends on every port when any port's usage passes an 8-bit threshold of 128-byte units, reset 0x40.
module eelc_lpi_ctrl #(
  parameter BW             = 14, // buffer usage width in bytes
  parameter EMPTY_UNIT_CYC = (`EELC_EMPTY_UNIT_NS + `EELC_CLK_PERIOD_NS - 1) / `EELC_CLK_PERIOD_NS // cycles per 1.3 ms
) (
  input  wire          ref_clk,        // system clock, 125 MHz
  input  wire          resetn,         // async reset, active low
  input  wire          wb_cyc_i,       // wishbone cycle
  input  wire          wb_stb_i,       // wishbone strobe
  input  wire          wb_we_i,        // wishbone write
  input  wire [11:0]   wb_adr_i,       // wishbone byte address
  input  wire [3:0]    wb_sel_i,       // wishbone byte lanes
  input  wire [31:0]   wb_dat_i,       // wishbone write data
  output reg  [31:0]   wb_dat_o,       // wishbone read data
  output reg           wb_ack_o,       // wishbone acknowledge
  input  wire          hwEee100En,     // 100base-tx eee enabled by negotiation
  input  wire          txLpiActive,    // transmit pcs sees lpi now
  input  wire          rxLpiActive,    // receive pcs sees lpi now
  input  wire          pageRxEvent,    // new negotiation page arrived
  input  wire          parDetFault,    // parallel detection fault
  input  wire          lpNextPageAble, // partner is next page able
  input  wire          lpAnAble,       // partner can auto-negotiate
  input  wire          p1QueueEmpty,   // port transmit queue empty
  input  wire          hostQueueEmpty, // host transmit queue empty
  input  wire          inputTraffic,   // ingress traffic seen
  input  wire [BW-1:0] p1BufUsage,     // port buffer usage, bytes
  input  wire [BW-1:0] hostBufUsage,   // host buffer usage, bytes
  output reg           lpiReqP1,       // lpi request, port
  output reg           lpiReqHost,     // lpi request, host port
  output reg           txHoldP1,       // port transmit held for lpi recovery
  output reg           npExchangeEn    // next page exchange enabled
);

localparam RECOV_UNIT_CYC = (`EELC_RECOV_UNIT_NS + `EELC_CLK_PERIOD_NS - 1) / `EELC_CLK_PERIOD_NS;

function [7:0] laneWr;
  input [7:0] cur;
  input [7:0] nw;
  input       en;
  begin
    laneWr = en ? nw : cur;
  end
endfunction

// software registers
reg  [7:0]  recovCnt_r;
reg         trafficEn_r;
reg  [5:0]  srcThr_r;
reg  [1:0]  pcsHi_r;
reg         pcsRsv9_r;
reg  [7:0]  pcsLo_r;
reg  [15:0] emptyWait_r;
reg  [7:0]  allThr_r;
reg         stRsv15_r;
reg  [1:0]  stRsv98_r;

// latching status
reg         txLpiLh_r;
reg         rxLpiLh_r;
reg         pdfLh_r;
reg         pageRxLh_r;

// bus decode
wire                  wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire                  wbWr  = wbReq & wb_we_i;
wire                  wbRd  = wbReq & ~wb_we_i;
wire [`EELC_IDX_W-1:0] idx  = wb_adr_i[11:2];
wire [7:0]            wd0   = wb_dat_i[7:0];
wire [7:0]            wd1   = wb_dat_i[15:8];

reg        hitStat;
reg        hitRecov;
reg        hitBl1;
reg        hitPcs;
reg        hitEmpty;
reg        hitBl2;
reg [15:0] rdData;

wire [15:0] statWord = {stRsv15_r, hwEee100En, txLpiLh_r, txLpiActive, rxLpiLh_r, rxLpiActive,
                        stRsv98_r, 1'h0, `EELC_ST_NPLOC, pdfLh_r, lpNextPageAble,
                        npExchangeEn,
                        pageRxLh_r,
                        lpAnAble};

always @* begin
  hitStat  = 1'h0;
  hitRecov = 1'h0;
  hitBl1   = 1'h0;
  hitPcs   = 1'h0;
  hitEmpty = 1'h0;
  hitBl2   = 1'h0;
  rdData   = 16'h0000;
  if (idx == `EELC_IDX_EEE_STAT) begin
    hitStat = 1'h1;
    rdData  = statWord;
  end else if (idx == `EELC_IDX_RECOV) begin
    hitRecov = 1'h1;
    rdData   = {8'h00, recovCnt_r};
  end else if (idx == `EELC_IDX_BL1) begin
    hitBl1 = 1'h1;
    rdData = {8'h00, trafficEn_r, 1'h0, srcThr_r};
  end else if (idx == `EELC_IDX_PCS) begin
    hitPcs = 1'h1;
    rdData = {pcsHi_r, 4'h0, pcsRsv9_r, npExchangeEn, pcsLo_r};
  end else if (idx == `EELC_IDX_EMPTY) begin
    hitEmpty = 1'h1;
    rdData   = emptyWait_r;
  end else if (idx == `EELC_IDX_BL2) begin
    hitBl2 = 1'h1;
    rdData = {`EELC_BL2_HI_RO, allThr_r};
  end
end

// one-cycle answer; unmapped addresses are acknowledged, read zero and drop writes
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    wb_ack_o <= 1'h0;
    wb_dat_o <= 32'h0000_0000;
  end else begin
    wb_ack_o <= wbReq;
    if (wbRd) begin
      wb_dat_o <= {16'h0000, rdData};
    end
  end
end

// register writes
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    recovCnt_r   <= `EELC_RST_RECOV;
    trafficEn_r  <= 1'h0;
    srcThr_r     <= `EELC_RST_SRC_THR;
    pcsHi_r      <= `EELC_RST_PCS_HI;
    pcsRsv9_r    <= `EELC_RST_PCS_R9;
    npExchangeEn <= `EELC_RST_NP_EN;
    pcsLo_r      <= `EELC_RST_PCS_LO;
    emptyWait_r  <= `EELC_RST_EMPTY;
    allThr_r     <= `EELC_RST_ALL_THR;
    stRsv15_r    <= `EELC_RST_ST_R15;
    stRsv98_r    <= `EELC_RST_ST_R98;
  end else if (wbWr) begin
    if (hitRecov) begin
      recovCnt_r <= laneWr(recovCnt_r, wd0, wb_sel_i[0]);
    end else if (hitBl1 && wb_sel_i[0]) begin
      trafficEn_r <= wd0[`EELC_BL1_TRAF_EN];
      srcThr_r    <= wd0[5:0];
    end else if (hitPcs) begin
      pcsLo_r <= laneWr(pcsLo_r, wd0, wb_sel_i[0]);
      if (wb_sel_i[1]) begin
        pcsHi_r      <= wd1[7:6];
        pcsRsv9_r    <= wb_dat_i[`EELC_PCS_R9];
        npExchangeEn <= wb_dat_i[`EELC_PCS_NP_EN];
      end
    end else if (hitEmpty) begin
      emptyWait_r <= {laneWr(emptyWait_r[15:8], wd1, wb_sel_i[1]),
                      laneWr(emptyWait_r[7:0], wd0, wb_sel_i[0])};
    end else if (hitBl2) begin
      allThr_r <= laneWr(allThr_r, wd0, wb_sel_i[0]);
    end else if (hitStat && wb_sel_i[1]) begin
      stRsv15_r <= wd1[7];
      stRsv98_r <= wd1[1:0];
    end
  end
end

// latching status: a set in the clearing cycle wins over the clear
wire statRead = wbRd & hitStat;
wire statW1c  = wbWr & hitStat & wb_sel_i[1];

always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    txLpiLh_r  <= 1'h0;
    rxLpiLh_r  <= 1'h0;
    pdfLh_r    <= 1'h0;
    pageRxLh_r <= 1'h0;
  end else begin
    txLpiLh_r  <= (txLpiLh_r & ~(statW1c & wb_dat_i[`EELC_ST_TXLPI_LH])) | txLpiActive;
    rxLpiLh_r  <= (rxLpiLh_r & ~(statW1c & wb_dat_i[`EELC_ST_RXLPI_LH])) | rxLpiActive;
    pdfLh_r    <= (pdfLh_r & ~statRead) | parDetFault;
    pageRxLh_r <= (pageRxLh_r & ~statRead) | pageRxEvent;
  end
end

// buffer load checks, each port against the shared 512-byte-unit threshold and the shared all-port threshold
wire srcOverP1;
wire srcOverHost;
wire allOverP1;
wire allOverHost;

eelc_load_cmp #(.BW(BW), .TW(6), .SHIFT(`EELC_SRC_SHIFT)) u_srcP1 (
  .clk    (ref_clk),
  .resetn (resetn),
  .usage  (p1BufUsage),
  .thr    (srcThr_r),
  .over_r (srcOverP1)
);

eelc_load_cmp #(.BW(BW), .TW(6), .SHIFT(`EELC_SRC_SHIFT)) u_srcHost (
  .clk    (ref_clk),
  .resetn (resetn),
  .usage  (hostBufUsage),
  .thr    (srcThr_r),
  .over_r (srcOverHost)
);

eelc_load_cmp #(.BW(BW), .TW(8), .SHIFT(`EELC_ALL_SHIFT)) u_allP1 (
  .clk    (ref_clk),
  .resetn (resetn),
  .usage  (p1BufUsage),
  .thr    (allThr_r),
  .over_r (allOverP1)
);

eelc_load_cmp #(.BW(BW), .TW(8), .SHIFT(`EELC_ALL_SHIFT)) u_allHost (
  .clk    (ref_clk),
  .resetn (resetn),
  .usage  (hostBufUsage),
  .thr    (allThr_r),
  .over_r (allOverHost)
);

// termination reasons; any one holds the empty timer at zero so entry restarts from scratch
wire trafficStop = trafficEn_r & inputTraffic;
wire allStop     = allOverP1 | allOverHost;
wire termP1      = trafficStop | allStop | srcOverP1;
wire termHost    = trafficStop | allStop | srcOverHost;
wire runP1       = hwEee100En & p1QueueEmpty & ~termP1;
wire runHost     = hwEee100En & hostQueueEmpty & ~termHost;
wire emptyDoneP1;
wire emptyDoneHost;

eelc_unit_timer #(.UNIT_CYC(EMPTY_UNIT_CYC), .PW(`EELC_PRE_W), .CW(16), .STRICT(1)) u_emptyP1 (
  .clk    (ref_clk),
  .resetn (resetn),
  .run    (runP1),
  .limit  (emptyWait_r),
  .done_r (emptyDoneP1)
);

eelc_unit_timer #(.UNIT_CYC(EMPTY_UNIT_CYC), .PW(`EELC_PRE_W), .CW(16), .STRICT(1)) u_emptyHost (
  .clk    (ref_clk),
  .resetn (resetn),
  .run    (runHost),
  .limit  (emptyWait_r),
  .done_r (emptyDoneHost)
);

wire lpiReqP1_nxt   = runP1 & emptyDoneP1;
wire lpiReqHost_nxt = runHost & emptyDoneHost;

// recovery hold starts when the port request falls and lasts the programmed units
reg  recov_r;
wire recovDone;
wire recov_nxt = lpiReqP1_nxt ? 1'h0 :
                 (lpiReqP1 & ~lpiReqP1_nxt) ? 1'h1 :
                 (recovDone ? 1'h0 : recov_r);

eelc_unit_timer #(.UNIT_CYC(RECOV_UNIT_CYC), .PW(`EELC_PRE_W), .CW(8), .STRICT(0)) u_recov (
  .clk    (ref_clk),
  .resetn (resetn),
  .run    (recov_r),
  .limit  (recovCnt_r),
  .done_r (recovDone)
);

always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    lpiReqP1   <= 1'h0;
    lpiReqHost <= 1'h0;
    recov_r    <= 1'h0;
    txHoldP1   <= 1'h0;
  end else begin
    lpiReqP1   <= lpiReqP1_nxt;
    lpiReqHost <= lpiReqHost_nxt;
    recov_r    <= recov_nxt;
    txHoldP1   <= recov_nxt;
  end
end

endmodule

// *** tb/eelc_lpi_ctrl_asserts.sv ***
// port checks for the eee lpi control block
`timescale 1ns/10ps
`include "eelc_consts.vh"
module eelc_lpi_ctrl_asserts (
  input logic        ref_clk,      // clock
  input logic        resetn,       // reset, active low
  input logic        wb_cyc_i,     // bus cycle
  input logic        wb_stb_i,     // bus strobe
  input logic        wb_we_i,      // bus write
  input logic [11:0] wb_adr_i,     // bus address
  input logic [3:0]  wb_sel_i,     // byte lanes
  input logic [31:0] wb_dat_i,     // write data
  input logic        wb_ack_o,     // acknowledge
  input logic        hwEee100En,   // eee resolved
  input logic        p1QueueEmpty, // port queue empty
  input logic        lpiReqP1,     // port request
  input logic        lpiReqHost,   // host request
  input logic        txHoldP1,     // recovery hold
  input logic        npExchangeEn  // next page enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic req;
  logic pcsWr;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign pcsWr = req && wb_we_i && wb_sel_i[1] && wb_adr_i[11:2] == `EELC_IDX_PCS;
  property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  property p_npWr; pcsWr |=> npExchangeEn == $past(wb_dat_i[8]); endproperty
  a_npWr: assert property (p_npWr) else $error("next page enable not written");
  property p_npKeep; !pcsWr |=> $stable(npExchangeEn); endproperty
  a_npKeep: assert property (p_npKeep) else $error("next page enable changed alone");
  property p_enGate; !hwEee100En ##1 !hwEee100En |-> !lpiReqP1 && !lpiReqHost; endproperty
  a_enGate: assert property (p_enGate) else $error("request without eee");
  property p_busy; !p1QueueEmpty |=> !lpiReqP1; endproperty
  a_busy: assert property (p_busy) else $error("request with queue busy");
  property p_rise; $rose(lpiReqP1) |-> $past(p1QueueEmpty) && $past(hwEee100En); endproperty
  a_rise: assert property (p_rise) else $error("request rose without cause");
  property p_hold; $fell(lpiReqP1) |-> ##[0:1] txHoldP1; endproperty
  a_hold: assert property (p_hold) else $error("no recovery hold after exit");
  property p_holdEnd; $rose(lpiReqP1) |-> ##[0:1] !txHoldP1; endproperty
  a_holdEnd: assert property (p_holdEnd) else $error("hold kept in lpi");
endmodule

bind eelc_lpi_ctrl eelc_lpi_ctrl_asserts eelc_lpi_ctrl_asserts_i (.ref_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .hwEee100En, .p1QueueEmpty,
  .lpiReqP1, .lpiReqHost, .txHoldP1, .npExchangeEn);

// *** tb/eelc_link_partner.sv ***
// link partner model: negotiation outcome, page arrival and lpi signalling
`timescale 1ns/10ps
module eelc_link_partner (
  input  logic clk,     // system clock
  input  logic resetn,  // reset, active low
  input  logic able,    // partner eee and negotiation capable
  input  logic pageReq, // partner sends a page
  input  logic npEn,    // local next page exchange on
  input  logic lpiIn,   // local lpi request
  output logic anAble,  // partner negotiation able
  output logic eeeOn,   // eee resolved
  output logic pageEvt, // page arrived
  output logic lpi      // lpi seen on the line
);
  assign anAble = able;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eeeOn <= 1'h0;
      pageEvt <= 1'h0;
      lpi <= 1'h0;
    end else begin
      // eee is only agreed through the next page exchange
      eeeOn <= able && npEn;
      pageEvt <= pageReq;
      lpi <= lpiIn && able;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the eee lpi control block
`timescale 1ns/10ps
module tb_top;
  logic        ref_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [11:0] wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic        hwEee100En, txLpiActive, rxLpiActive, pageRxEvent, lpNextPageAble, lpAnAble;
  logic        parDetFault = 0, p1QueueEmpty = 0, hostQueueEmpty = 0, inputTraffic = 0;
  logic [13:0] p1BufUsage = 0, hostBufUsage = 0;
  logic        lpiReqP1, lpiReqHost, txHoldP1, npExchangeEn, able = 0, pageReq = 0, lpi;
  logic [15:0] q;
  int          n_errors = 0, compares = 0, k;
  assign txLpiActive = lpi;
  assign rxLpiActive = lpi;
  assign lpNextPageAble = lpAnAble;
  eelc_lpi_ctrl #(.EMPTY_UNIT_CYC(4)) eelc_lpi_ctrl_i (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .hwEee100En, .txLpiActive,
    .rxLpiActive, .pageRxEvent, .parDetFault, .lpNextPageAble, .lpAnAble, .p1QueueEmpty,
    .hostQueueEmpty, .inputTraffic, .p1BufUsage, .hostBufUsage, .lpiReqP1, .lpiReqHost,
    .txHoldP1, .npExchangeEn);
  eelc_link_partner eelc_link_partner_i (.clk(ref_clk), .resetn, .able, .pageReq,
    .npEn(npExchangeEn), .lpiIn(lpiReqP1), .anAble(lpAnAble), .eeeOn(hwEee100En),
    .pageEvt(pageRxEvent), .lpi);
  always #4 ref_clk = ~ref_clk;
  task automatic tk(int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [9:0] idx, input logic [15:0] d);
    int n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, d};
    do begin
      tk(1);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 50) begin
      chk(16'h0, 16'h1);
      end_sim();
    end
    tk(1);
  endtask
  // waits for the port request; the count is the latency seen
  task automatic wt();
    k = 0;
    while (lpiReqP1 !== 1'h1 && k < 60) begin
      tk(1);
      k++;
    end
    if (k >= 60) begin
      chk(16'h0, 16'h1);
      end_sim();
    end
  endtask
  task automatic t_regs();
    logic [9:0]  ix [7] = '{10'h0e4, 10'h0e6, 10'h0e7, 10'h0f2, 10'h0f4, 10'h0f6, 10'h0e5};
    logic [15:0] ex [7] = '{16'h8064, 16'h0027, 16'h0008, 16'h0327, 16'h03e8, 16'h0140, 16'h0};
    for (int i = 0; i < 7; i++) begin
      wb(1'h0, ix[i], 16'h0);
      chk(q, ex[i]);
    end
    wb(1'h1, 10'h0e7, 16'hffff);
    wb(1'h0, 10'h0e7, 16'h0);
    chk(q, 16'h00bf);
    wb(1'h1, 10'h0f6, 16'hffff);
    wb(1'h0, 10'h0f6, 16'h0);
    chk(q, 16'h01ff);
    wb(1'h1, 10'h0f6, 16'h0040);
    wb(1'h1, 10'h0e7, 16'h0008);
  endtask
  task automatic t_status();
    able <= 1'h1;
    pageReq <= 1'h1;
    tk(1);
    pageReq <= 1'h0;
    tk(4);
    wb(1'h0, 10'h0e4, 16'h0);
    chk(q & 16'h0007, 16'h0007);
    wb(1'h0, 10'h0e4, 16'h0);
    chk(q & 16'h0007, 16'h0005);
  endtask
  task automatic t_empty();
    wb(1'h1, 10'h0f4, 16'h0002);
    p1QueueEmpty <= 1'h1;
    hostQueueEmpty <= 1'h1;
    wt();
    chk(16'(k >= 12 && k <= 16), 16'h1);
    chk(16'(lpiReqHost), 16'h1);
    able <= 1'h0;
    tk(4);
    chk(16'({lpiReqP1, lpiReqHost}), 16'h0);
    able <= 1'h1;
  endtask
  task automatic t_recov();
    wb(1'h1, 10'h0e6, 16'h0002);
    wt();
    p1QueueEmpty <= 1'h0;
    tk(2);
    chk(16'(txHoldP1), 16'h1);
    k = 0;
    while (txHoldP1 === 1'h1 && k < 400) begin
      tk(1);
      k++;
    end
    chk(16'(k >= 156 && k <= 164), 16'h1);
    if (k >= 400) end_sim();
  endtask
  task automatic t_traffic();
    p1QueueEmpty <= 1'h1;
    wt();
    inputTraffic <= 1'h1;
    tk(4);
    chk(16'(lpiReqP1), 16'h1);
    wb(1'h1, 10'h0e7, 16'h0088);
    tk(1);
    chk(16'(lpiReqP1), 16'h0);
    inputTraffic <= 1'h0;
    wb(1'h1, 10'h0e7, 16'h0008);
  endtask
  task automatic t_load();
    wt();
    p1BufUsage <= 14'h1000;
    tk(4);
    chk(16'(lpiReqP1), 16'h1);
    p1BufUsage <= 14'h1001;
    tk(4);
    chk(16'({lpiReqP1, lpiReqHost}), 16'h1);
    p1BufUsage <= 14'h2001;
    tk(4);
    chk(16'({lpiReqP1, lpiReqHost}), 16'h0);
    p1BufUsage <= 14'h0;
  endtask
  task automatic t_np();
    wb(1'h1, 10'h0f2, 16'h0227);
    chk(16'(npExchangeEn), 16'h0);
    wb(1'h0, 10'h0e4, 16'h0);
    chk(q & 16'h4004, 16'h0);
    wb(1'h1, 10'h0f2, 16'h0327);
    chk(16'(npExchangeEn), 16'h1);
  endtask
  initial begin
    tk(5);
    resetn <= 1'h1;
    tk(1);
    t_regs();
    t_status();
    t_empty();
    t_recov();
    t_traffic();
    t_load();
    t_np();
    end_sim();
  end
endmodule
